// file: design/tlic_pkg.sv
// Purpose: Constants for the two-level interrupt controller
// Assumes: 8-bit special register port from the core, 16-bit code addresses
// Notes:   Source indices follow the fixed polling order, index 0 polled first
//
// Notes on behaviour
// - Global enable low blocks all sources.
// - Main enable register gates seven main sources.
// - Secondary register enables interval, supply, serial.
// - Priority register: one bit per main source, bit7 ignored.
// - Secondary register holds three priority bits.
// - High-level request preempts low-level service.
// - Simultaneous requests: high level granted first.
// - Same-level requests never preempt running service.
// - Same-level ties follow the fixed polling order.
// - Program counter pushed before vector jump.
// - Vectors for ext0, timers, ext1, uart.
// - Vectors for adc, serial, supply, interval, watchdog.
package tlic_pkg;

  // ==========================================================
  // Register addresses and reset values
  localparam logic [7:0] TLIC_ADDR_IE_MAIN  = 8'hA8;
  localparam logic [7:0] TLIC_ADDR_SECONDARY_ENABLE_PRIORITY    = 8'hA9;
  localparam logic [7:0] TLIC_ADDR_PRIO     = 8'hB8;
  localparam logic [7:0] TLIC_RST_IE_MAIN   = 8'h00;
  localparam logic [7:0] TLIC_RST_SECONDARY_ENABLE_PRIORITY     = 8'hA0;
  localparam logic [7:0] TLIC_RST_PRIO      = 8'h00;
  localparam logic [7:0] TLIC_PRIO_WMASK    = 8'h7F;
  localparam logic [7:0] TLIC_SECONDARY_ENABLE_PRIORITY_WMASK   = 8'h77;

  // ==========================================================
  // Field positions
  localparam int TLIC_BIT_GLOBAL_EN   = 7;
  localparam int TLIC_BIT_ADC         = 6;
  localparam int TLIC_BIT_TIMER2      = 5;
  localparam int TLIC_BIT_UART        = 4;
  localparam int TLIC_BIT_TIMER1      = 3;
  localparam int TLIC_BIT_EXT1        = 2;
  localparam int TLIC_BIT_TIMER0      = 1;
  localparam int TLIC_BIT_EXT0        = 0;
  localparam int TLIC_BIT_INTV_LVL    = 6;
  localparam int TLIC_BIT_SUPPLY_LVL  = 5;
  localparam int TLIC_BIT_SERIAL_LVL  = 4;
  localparam int TLIC_BIT_INTV_EN     = 2;
  localparam int TLIC_BIT_SUPPLY_EN   = 1;
  localparam int TLIC_BIT_SERIAL_EN   = 0;

  // ==========================================================
  // Sources in polling order
  localparam int TLIC_NSRC         = 11;
  localparam int TLIC_SRC_SUPPLY   = 0;
  localparam int TLIC_SRC_WATCHDOG = 1;
  localparam int TLIC_SRC_EXT0     = 2;
  localparam int TLIC_SRC_ADC      = 3;
  localparam int TLIC_SRC_TIMER0   = 4;
  localparam int TLIC_SRC_EXT1     = 5;
  localparam int TLIC_SRC_TIMER1   = 6;
  localparam int TLIC_SRC_SERIAL   = 7;
  localparam int TLIC_SRC_UART     = 8;
  localparam int TLIC_SRC_TIMER2   = 9;
  localparam int TLIC_SRC_INTV     = 10;

  // ==========================================================
  // Vector addresses, indexed as above
  localparam logic [15:0] TLIC_VEC_SUPPLY   = 16'h0043;
  localparam logic [15:0] TLIC_VEC_WATCHDOG = 16'h005B;
  localparam logic [15:0] TLIC_VEC_EXT0     = 16'h0003;
  localparam logic [15:0] TLIC_VEC_ADC      = 16'h0033;
  localparam logic [15:0] TLIC_VEC_TIMER0   = 16'h000B;
  localparam logic [15:0] TLIC_VEC_EXT1     = 16'h0013;
  localparam logic [15:0] TLIC_VEC_TIMER1   = 16'h001B;
  localparam logic [15:0] TLIC_VEC_SERIAL   = 16'h003B;
  localparam logic [15:0] TLIC_VEC_UART     = 16'h0023;
  localparam logic [15:0] TLIC_VEC_TIMER2   = 16'h002B;
  localparam logic [15:0] TLIC_VEC_INTV     = 16'h0053;

  typedef enum logic [2:0] {
    TLIC_IDLE  = 3'b001,
    TLIC_CALL  = 3'b010,
    TLIC_WAIT  = 3'b100
  } tlic_state_t;

endpackage

// file: design/tlic_pick.sv
// Purpose: Fixed-order pick of the first set request in a vector
// Assumes: Index 0 has the highest precedence
// Notes:   Pure combinational
`timescale 1ns/1ns
module tlic_pick #(
  parameter int N = 11
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [3:0]        idx
);
  import tlic_pkg::*;

  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

// file: design/tlic_top.sv
// Purpose: Two-level interrupt controller with vector call request
// Assumes: Requests are same-clock levels from the sources' flag logic
// Notes:   Core acks each call, and pulses a return strobe on return
`timescale 1ns/1ns
module tlic_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  output logic [7:0]       reg_rdata,
  input  wire logic        supply_monitor_request,
  input  wire logic        watchdog_request,
  input  wire logic        external0_request,
  input  wire logic        adc_ready_request,
  input  wire logic        timer0_overflow_request,
  input  wire logic        external1_request,
  input  wire logic        timer1_overflow_request,
  input  wire logic        serial_port_request,
  input  wire logic        uart_rx_tx_request,
  input  wire logic        timer2_request,
  input  wire logic        interval_counter_request,
  output logic             call_req,
  output logic [15:0]      call_vector,
  output logic             push_pc,
  input  wire logic        call_ack,
  input  wire logic        reti_done,
  output logic             high_active,
  output logic             low_active
);
  import tlic_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] interrupt_enable_main;
  logic [7:0] secondary_enable_priority;
  logic [7:0] priority_level_main;

  // Address decode shared by write strobes and read mux
  wire sel_ie  = (reg_addr == TLIC_ADDR_IE_MAIN);
  wire sel_ip2 = (reg_addr == TLIC_ADDR_SECONDARY_ENABLE_PRIORITY);
  wire sel_ip  = (reg_addr == TLIC_ADDR_PRIO);

  wire wr_ie  = reg_wr && sel_ie;
  wire wr_ip2 = reg_wr && sel_ip2;
  wire wr_ip  = reg_wr && sel_ip;

  // Bit 3 stored as written; software must keep it zero
  wire [7:0] ip2_wval = (reg_wdata & TLIC_SECONDARY_ENABLE_PRIORITY_WMASK) | (reg_wdata & 8'h08);

  // Next values; unimplemented secondary bit 7 keeps its reset value
  wire [7:0] next_ie  = wr_ie ? reg_wdata : interrupt_enable_main;
  wire [7:0] next_ip2 = wr_ip2 ? (ip2_wval | (secondary_enable_priority & 8'h80)) :
                                 secondary_enable_priority;
  wire [7:0] next_ip  = wr_ip ? (reg_wdata & TLIC_PRIO_WMASK) : priority_level_main;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_main     <= TLIC_RST_IE_MAIN;
      secondary_enable_priority <= TLIC_RST_SECONDARY_ENABLE_PRIORITY;
      priority_level_main       <= TLIC_RST_PRIO;
    end else begin
      interrupt_enable_main     <= next_ie;
      secondary_enable_priority <= next_ip2;
      priority_level_main       <= next_ip;
    end
  end

  wire [7:0] rd_mux = sel_ie  ? interrupt_enable_main :
                      sel_ip2 ? secondary_enable_priority :
                      sel_ip  ? priority_level_main : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rd_mux;
  end

  // ==========================================================
  // Per-source request, enable and level in polling order
  wire [10:0] raw_req = {interval_counter_request, timer2_request, uart_rx_tx_request,
                         serial_port_request, timer1_overflow_request, external1_request,
                         timer0_overflow_request, adc_ready_request, external0_request,
                         watchdog_request, supply_monitor_request};

  logic [7:0] ie;
  logic [7:0] ip;
  logic [7:0] ip2;
  assign ie  = interrupt_enable_main;
  assign ip  = priority_level_main;
  assign ip2 = secondary_enable_priority;

  // Watchdog has no enable bit here; its own enable lives in the watchdog
  wire [10:0] src_en = {ip2[TLIC_BIT_INTV_EN], ie[TLIC_BIT_TIMER2], ie[TLIC_BIT_UART],
                        ip2[TLIC_BIT_SERIAL_EN], ie[TLIC_BIT_TIMER1], ie[TLIC_BIT_EXT1],
                        ie[TLIC_BIT_TIMER0], ie[TLIC_BIT_ADC], ie[TLIC_BIT_EXT0],
                        1'b1, ip2[TLIC_BIT_SUPPLY_EN]};

  wire [10:0] src_hi = {ip2[TLIC_BIT_INTV_LVL], ip[TLIC_BIT_TIMER2], ip[TLIC_BIT_UART],
                        ip2[TLIC_BIT_SERIAL_LVL], ip[TLIC_BIT_TIMER1], ip[TLIC_BIT_EXT1],
                        ip[TLIC_BIT_TIMER0], ip[TLIC_BIT_ADC], ip[TLIC_BIT_EXT0],
                        1'b0, ip2[TLIC_BIT_SUPPLY_LVL]};

  // Per-source gating: own enable, global enable, then split by level
  // Global enable off masks every source, watchdog included
  wire [10:0] live;
  wire [10:0] live_hi;
  wire [10:0] live_lo;

  genvar g;
  generate
    for (g = 0; g < TLIC_NSRC; g++) begin : g_src
      assign live[g]    = raw_req[g] && src_en[g] && ie[TLIC_BIT_GLOBAL_EN];
      assign live_hi[g] = live[g] && src_hi[g];
      assign live_lo[g] = live[g] && !src_hi[g];
    end
  endgenerate

  // ==========================================================
  // Level selection
  logic       any_hi;
  logic       any_lo;
  logic [3:0] idx_hi;
  logic [3:0] idx_lo;

  tlic_pick #(.N(TLIC_NSRC)) u_pick_hi (
    .req (live_hi),
    .any (any_hi),
    .idx (idx_hi)
  );
  tlic_pick #(.N(TLIC_NSRC)) u_pick_lo (
    .req (live_lo),
    .any (any_lo),
    .idx (idx_lo)
  );

  // High allowed unless high service running; low only when idle
  wire grant_hi = any_hi && !high_active;
  wire grant_lo = any_lo && !high_active && !low_active && !any_hi;
  wire [3:0] win_idx = grant_hi ? idx_hi : idx_lo;

  logic [15:0] win_vec;
  always_comb begin
    case (win_idx)
      4'h0:    win_vec = TLIC_VEC_SUPPLY;
      4'h1:    win_vec = TLIC_VEC_WATCHDOG;
      4'h2:    win_vec = TLIC_VEC_EXT0;
      4'h3:    win_vec = TLIC_VEC_ADC;
      4'h4:    win_vec = TLIC_VEC_TIMER0;
      4'h5:    win_vec = TLIC_VEC_EXT1;
      4'h6:    win_vec = TLIC_VEC_TIMER1;
      4'h7:    win_vec = TLIC_VEC_SERIAL;
      4'h8:    win_vec = TLIC_VEC_UART;
      4'h9:    win_vec = TLIC_VEC_TIMER2;
      4'hA:    win_vec = TLIC_VEC_INTV;
      default: win_vec = TLIC_VEC_EXT0;
    endcase
  end

  // ==========================================================
  // Call sequencing and active-level tracking
  tlic_state_t state;
  logic        call_is_hi;

  // Return beats a new grant; returns only honoured between calls
  wire in_idle    = (state == TLIC_IDLE);
  wire take_reti  = in_idle && reti_done;
  wire take_grant = in_idle && !reti_done && (grant_hi || grant_lo);
  wire take_ack   = (state == TLIC_WAIT) && call_ack;

  // Return releases the innermost level: high if running, else low
  wire rel_hi = take_reti && high_active;
  wire rel_lo = take_reti && !high_active;
  wire set_hi = take_ack && call_is_hi;
  wire set_lo = take_ack && !call_is_hi;

  // Vector latched at grant so it cannot move while the core stalls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= TLIC_IDLE;
      call_req    <= 1'b0;
      push_pc     <= 1'b0;
      call_vector <= 16'h0000;
      call_is_hi  <= 1'b0;
    end else begin
      push_pc <= 1'b0;
      case (state)
        TLIC_IDLE: begin
          if (take_grant) begin
            state       <= TLIC_CALL;
            push_pc     <= 1'b1;
            call_vector <= win_vec;
            call_is_hi  <= grant_hi;
          end
        end
        TLIC_CALL: begin
          // Push issued first, vector jump requested next cycle
          call_req <= 1'b1;
          state    <= TLIC_WAIT;
        end
        TLIC_WAIT: begin
          if (take_ack) begin
            call_req <= 1'b0;
            state    <= TLIC_IDLE;
          end
        end
        default: begin
          state    <= TLIC_IDLE;
          call_req <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Active service levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_active <= 1'b0;
      low_active  <= 1'b0;
    end else begin
      high_active <= set_hi || (high_active && !rel_hi);
      low_active  <= set_lo || (low_active && !rel_lo);
    end
  end
endmodule

// file: sim/tlic_checker.sv
// Purpose: Concurrent checks on the call link of tlic_top
// Assumes: Core acks each call and returns only with no call pending
// Notes:   Bound to every tlic_top instance
`timescale 1ns/1ns
module tlic_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        call_req,
  input wire logic [15:0] call_vector,
  input wire logic        push_pc,
  input wire logic        call_ack,
  input wire logic        reti_done,
  input wire logic        high_active,
  input wire logic        low_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire idle = !call_req && !push_pc;
  sequence s_grant;
    push_pc ##1 call_req;
  endsequence
  sequence s_quiet;
    !push_pc [*2];
  endsequence
  grant_seq_a: assert property (push_pc |-> s_grant)
    else $error("call request missing after push");
  push_gap_a: assert property (push_pc |=> s_quiet)
    else $error("push repeated too soon");
  call_hold_a: assert property (call_req && !call_ack |=> call_req)
    else $error("call request dropped before ack");
  ack_level_a: assert property (call_req && call_ack |=> !call_req && (high_active || low_active))
    else $error("ack did not start service level");
  vec_hold_a: assert property (call_req && !call_ack |=> $stable(call_vector))
    else $error("vector moved during call");
  vec_form_a: assert property (call_req |-> call_vector[2:0] == 3'h3 && call_vector[15:7] == 9'h0)
    else $error("vector outside table");
  high_nopre_a: assert property (high_active |-> !push_pc)
    else $error("grant during high service");
  hi_release_a: assert property (reti_done && high_active && idle |=> !high_active && $stable(low_active))
    else $error("return did not release high level");
  lo_release_a: assert property (reti_done && !high_active && low_active && idle |=> !low_active)
    else $error("return did not release low level");
endmodule
bind tlic_top tlic_checker tlic_checker_i (.ref_clk(ref_clk), .rst_n(rst_n), .call_req(call_req),
  .call_vector(call_vector), .push_pc(push_pc), .call_ack(call_ack), .reti_done(reti_done),
  .high_active(high_active), .low_active(low_active));

// file: sim/tlic_core_model.sv
// Purpose: Core sequencer stand-in: acks calls, issues returns
// Assumes: ack_delay cycles of stall before each ack
// Notes:   Drives only after the rising edge
`timescale 1ns/1ns
module tlic_core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       call_req,
  input  wire logic       reti_cmd,
  input  wire logic [1:0] ack_delay,
  output logic            call_ack,
  output logic            reti_done
);
  logic [1:0] stall_cnt;
  wire        waiting = call_req && !call_ack;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      call_ack  <= 1'b0;
      reti_done <= 1'b0;
      stall_cnt <= 2'h0;
    end else begin
      call_ack  <= waiting && stall_cnt >= ack_delay;
      stall_cnt <= waiting ? stall_cnt + 2'h1 : 2'h0;
      reti_done <= reti_cmd;
    end
  end
endmodule

// file: sim/tlic_top_tb_top.sv
// Purpose: Self-checking bench for tlic_top
// Assumes: Requests held until their service returns
// Notes:   Expected vectors queued, compared on each push
`timescale 1ns/1ns
module tlic_top_tb_top;
  import tlic_pkg::*;
  logic        ref_clk = 0, rst_n = 0, reg_wr = 0, reti_cmd = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic        call_req, push_pc, call_ack, reti_done, high_active, low_active;
  logic [1:0]  ack_delay = 0;
  logic [15:0] call_vector;
  logic [10:0] req = 0;
  logic [31:0] seed = 32'hC2F5;
  int          err_total = 0, checks = 0, i;
  logic [15:0] exp_q[$];
  logic [15:0] vec[11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                           16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  tlic_top tlic_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .supply_monitor_request(req[0]), .watchdog_request(req[1]), .external0_request(req[2]),
    .adc_ready_request(req[3]), .timer0_overflow_request(req[4]), .external1_request(req[5]),
    .timer1_overflow_request(req[6]), .serial_port_request(req[7]),
    .uart_rx_tx_request(req[8]), .timer2_request(req[9]), .interval_counter_request(req[10]),
    .call_req(call_req), .call_vector(call_vector), .push_pc(push_pc), .call_ack(call_ack),
    .reti_done(reti_done), .high_active(high_active), .low_active(low_active));
  tlic_core_model tlic_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .call_req(call_req),
    .reti_cmd(reti_cmd), .ack_delay(ack_delay), .call_ack(call_ack), .reti_done(reti_done));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] a;
    a = s ^ (s << 13);
    a = a ^ (a >> 17);
    return a ^ (a << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic wait_act(input logic hi);
    int n;
    n = 0;
    while ((hi ? high_active : low_active) !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 100) begin
        err_total++;
        print_verdict();
      end
    end
  endtask
  task automatic rel(input int s);
    @(negedge ref_clk);
    req[s] = 0;
    reti_cmd = 1;
    @(negedge ref_clk);
    reti_cmd = 0;
    @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (push_pc === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious call_vector", 16'hFFFF, call_vector);
      else chk("call_vector", exp_q.pop_front(), call_vector);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1;
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'hA0);
    rd(8'hB8, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h7F);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(8'hA8, seed[7:0]);
      rd(8'hA8, seed[7:0]);
    end
    wr(8'hB8, 8'h00);
    wr(8'hA8, 8'h7F);
    wr(8'hA9, 8'h07);
    rd(8'hA9, 8'h87);
    req = 11'h7FF;
    repeat (20) @(negedge ref_clk);
    for (i = 0; i < 11; i++) exp_q.push_back(vec[i]);
    wr(8'hA8, 8'hFF);
    for (i = 0; i < 11; i++) begin
      seed = xs(seed);
      ack_delay = seed[1:0];
      wait_act(0);
      rel(i);
    end
    wr(8'hA8, 8'h80);
    wr(8'hA9, 8'h00);
    req = 11'h7FD;
    repeat (20) @(negedge ref_clk);
    req = 0;
    wr(8'hA9, 8'h47);
    rd(8'hA9, 8'hC7);
    exp_q.push_back(16'h0053);
    exp_q.push_back(16'h003B);
    req[10] = 1;
    req[7] = 1;
    wait_act(1);
    rel(10);
    wait_act(0);
    rel(7);
    wr(8'hB8, 8'h08);
    wr(8'hA8, 8'h8A);
    exp_q.push_back(16'h001B);
    exp_q.push_back(16'h000B);
    exp_q.push_back(16'h001B);
    req[4] = 1;
    req[6] = 1;
    wait_act(1);
    repeat (10) @(negedge ref_clk);
    rel(6);
    wait_act(0);
    req[6] = 1;
    wait_act(1);
    rel(6);
    chk("low_active", 16'h1, {15'h0, low_active});
    rel(4);
    chk("low_active", 16'h0, {15'h0, low_active});
    wr(8'hB8, 8'h01);
    wr(8'hA8, 8'h81);
    wr(8'hA9, 8'h22);
    exp_q.push_back(16'h0043);
    exp_q.push_back(16'h0003);
    req[0] = 1;
    req[2] = 1;
    wait_act(1);
    repeat (10) @(negedge ref_clk);
    rel(0);
    wait_act(1);
    rel(2);
    chk("high_active", 16'h0, {15'h0, high_active});
    chk("pending calls", 16'h0, 16'(exp_q.size()));
    print_verdict();
  end
endmodule
